// [p9m_port9.sv]
// How it works
// R1: reading the port returns latch bits where direction is 1, except bit 6.
// R2: reading the port returns pin levels where direction is 0.
// R3: latch bit 6 is read-only and always reads the pin level.
// R4: expanded: pin 7 is wait input, else i2c data, else general i/o.
// R5: single-chip: wait select ignored; pin 7 is i2c data or general i/o.
// R6: pin 6 is input, subclock input, or clock output per direction/enable.
// R7: software keeps pin 6 direction 0 while using subclock input.
// R8: pin 5 drives address/io strobe expanded; host select one or i/o single.
// R9: pin 4 drives high write strobe expanded; host write or i/o single.
// R10: pin 3 drives read strobe expanded; host read or i/o single.
// R11: pin 2 is general i/o, also feeds interrupt zero when enabled.
// R12: pin 1 is general i/o, also feeds interrupt one when enabled.
// R13: expanded pin 0 drives low write when bus width 0, else i/o.
// R14: single-chip pin 0 is host select two when all three enables set.
// R15: pin 0 feeds interrupt two when enabled, unless expanded narrow bus.
// R16: pin 0 feeds converter trigger when both trigger selects are 1.
// R17: direction is write-only, resets to 40h in mode 1, else 00h.
// R18: general outputs drive the latch bit; writes reach the pin at the same edge as the latch.
module p9m_port9 #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              mode_one,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        pin_in,
  output logic      [7:0]        pin_out,
  output logic      [7:0]        pin_oe,
  input  wire logic              address_strobe,
  input  wire logic              io_space_strobe,
  input  wire logic              high_write_strobe,
  input  wire logic              bus_read_strobe,
  input  wire logic              low_write_strobe,
  input  wire logic              sysclk_out,
  input  wire logic              i2c_drive_low,
  output logic                   wait_input,
  output logic                   i2c_data_line_zero,
  output logic                   subclock_input,
  output logic                   host_select_one,
  output logic                   host_write_strobe,
  output logic                   host_read_strobe,
  output logic                   ext_interrupt_zero,
  output logic                   ext_interrupt_one,
  output logic                   ext_interrupt_two,
  output logic                   converter_ext_trigger,
  output logic                   host_select_two
);

  // offsets need at least four address bits
  if (ADDR_W < 4 || ADDR_W > 8) begin : g_chk
    $error("p9m_port9: ADDR_W must lie between 4 and 8");
  end

  typedef struct packed {
    logic               init_done;
    logic [7:0]         latch;
    logic [7:0]         dir;
    p9m_pkg::p9m_cfg_t  cfg;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic [7:0]         pin_out;
    logic [7:0]         pin_oe;
    p9m_pkg::p9m_feed_t feed;
  } p9m_state_t;

  p9m_state_t s_q;
  p9m_state_t s_d;
  p9m_mux_if  mif ();
  logic [7:0] addr8;
  logic       setup;
  logic       wr_done;

  p9m_pin_mux u_mux (
    .m (mif.mux)
  );

  assign addr8   = 8'(paddr);
  assign setup   = psel && !penable;
  assign wr_done = psel && penable && s_q.pready && pwrite && !s_q.pslverr;

  // next state: strap load, apb decode, then pin function from new state
  always_comb begin
    s_d         = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    // strap caught once after reset release, not under the reset itself
    if (!s_q.init_done) begin
      s_d.init_done = 1'b1;
      s_d.dir = mode_one ? p9m_pkg::DIR_RST_MODE1
                         : p9m_pkg::DIR_RST_SINGLE; // see R17
      s_d.cfg.expanded_mode_enable = mode_one;
    end
    // answer prepared in the setup cycle, so no wait state
    if (setup) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      unique case (addr8)
        p9m_pkg::OFF_DATA: begin
          s_d.prdata[7:0] = (s_q.dir & ~p9m_pkg::RO_MASK & s_q.latch) |
                            (~(s_q.dir & ~p9m_pkg::RO_MASK) & pin_in);
        end // see R1 see R2 see R3
        p9m_pkg::OFF_DIR:   s_d.prdata[7:0] = 8'h00; // see R17
        p9m_pkg::OFF_CFG:   s_d.prdata[p9m_pkg::CFG_W-1:0] = s_q.cfg;
        p9m_pkg::OFF_DRIVE: s_d.prdata[7:0] = s_q.pin_oe;
        default:            s_d.pslverr = 1'b1;
      endcase
    end
    // writes land only at the completing edge of the access phase
    if (wr_done) begin
      unique case (addr8)
        p9m_pkg::OFF_DATA: begin
          s_d.latch = (pwdata[7:0] & ~p9m_pkg::RO_MASK) |
                      (s_q.latch & p9m_pkg::RO_MASK); // see R3
        end
        p9m_pkg::OFF_DIR: s_d.dir = pwdata[7:0]; // see R17
        p9m_pkg::OFF_CFG: s_d.cfg = p9m_pkg::p9m_cfg_t'(
                                      pwdata[p9m_pkg::CFG_W-1:0]);
        default: ;
      endcase
    end
    // pins follow the state being written, so a write shows at once
    s_d.pin_out = mif.pin_out; // see R18
    s_d.pin_oe  = mif.pin_oe;
    s_d.feed    = mif.feed;
  end

  // mux sees the next state and the pins sampled at this edge
  assign mif.latch  = s_d.latch;
  assign mif.dir    = s_d.dir;
  assign mif.cfg    = s_d.cfg;
  assign mif.pin_in = pin_in;
  assign mif.src    = '{address_strobe, io_space_strobe, high_write_strobe,
                        bus_read_strobe, low_write_strobe, sysclk_out,
                        i2c_drive_low};

  // single state register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{init_done: 1'b0, latch: p9m_pkg::LATCH_RST,
               dir: p9m_pkg::DIR_RST_SINGLE, cfg: p9m_pkg::CFG_RST,
               pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
               pin_out: 8'h00, pin_oe: 8'h00, feed: p9m_pkg::FEED_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  // every output straight from the state register
  assign prdata                = s_q.prdata;
  assign pready                = s_q.pready;
  assign pslverr               = s_q.pslverr;
  assign pin_out               = s_q.pin_out;
  assign pin_oe                = s_q.pin_oe;
  assign wait_input            = s_q.feed.wait_input;
  assign i2c_data_line_zero    = s_q.feed.i2c_data_line_zero;
  assign subclock_input        = s_q.feed.subclock_input;
  assign host_select_one       = s_q.feed.host_select_one;
  assign host_write_strobe     = s_q.feed.host_write_strobe;
  assign host_read_strobe      = s_q.feed.host_read_strobe;
  assign ext_interrupt_zero    = s_q.feed.ext_interrupt_zero;
  assign ext_interrupt_one     = s_q.feed.ext_interrupt_one;
  assign ext_interrupt_two     = s_q.feed.ext_interrupt_two;
  assign converter_ext_trigger = s_q.feed.converter_ext_trigger;
  assign host_select_two       = s_q.feed.host_select_two;

  // checks on the registered outputs against their causes
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_r1;
    setup && addr8 == p9m_pkg::OFF_DATA |=>
      ((prdata[7:0] ^ $past(s_q.latch)) & $past(s_q.dir) &
       ~p9m_pkg::RO_MASK) == 8'h00;
  endproperty
  a_r1: assert property (p_r1) else $error("latch not read back"); // see R1

  property p_r2;
    setup && addr8 == p9m_pkg::OFF_DATA |=>
      ((prdata[7:0] ^ $past(pin_in)) & ~$past(s_q.dir)) == 8'h00;
  endproperty
  a_r2: assert property (p_r2) else $error("pin level not read"); // see R2

  property p_r3;
    setup && addr8 == p9m_pkg::OFF_DATA |=>
      prdata[p9m_pkg::PIN_CLK] == $past(pin_in[p9m_pkg::PIN_CLK]) ##1
      !pready;
  endproperty
  a_r3: assert property (p_r3) else $error("bit 6 not pin level"); // see R3

  property p_r4;
    s_q.cfg.expanded_mode_enable && s_q.cfg.wait_mode_select_hi |->
      !pin_oe[p9m_pkg::PIN_SDA] &&
      wait_input == $past(pin_in[p9m_pkg::PIN_SDA]);
  endproperty
  a_r4: assert property (p_r4) else $error("pin 7 not wait input"); // see R4

  property p_r5;
    !s_q.cfg.expanded_mode_enable && !s_q.cfg.i2c_unit_enable |->
      pin_oe[p9m_pkg::PIN_SDA] == s_q.dir[p9m_pkg::PIN_SDA] &&
      pin_out[p9m_pkg::PIN_SDA] == s_q.latch[p9m_pkg::PIN_SDA];
  endproperty
  a_r5: assert property (p_r5) else $error("pin 7 not gpio"); // see R5

  property p_r6;
    !s_q.dir[p9m_pkg::PIN_CLK] && s_q.cfg.subclock_input_enable |->
      !pin_oe[p9m_pkg::PIN_CLK] &&
      subclock_input == $past(pin_in[p9m_pkg::PIN_CLK]);
  endproperty
  a_r6: assert property (p_r6) else $error("subclock not routed"); // see R6

  property p_r8;
    s_q.cfg.expanded_mode_enable |-> pin_oe[p9m_pkg::PIN_ADDR_ST] &&
      pin_out[p9m_pkg::PIN_ADDR_ST] == (s_q.cfg.io_space_strobe_enable ?
      $past(io_space_strobe) : $past(address_strobe));
  endproperty
  a_r8: assert property (p_r8) else $error("pin 5 strobe wrong"); // see R8

  property p_r9;
    !s_q.cfg.expanded_mode_enable && s_q.cfg.host_port_enable |->
      !pin_oe[p9m_pkg::PIN_HI_WR] &&
      host_write_strobe == $past(pin_in[p9m_pkg::PIN_HI_WR]);
  endproperty
  a_r9: assert property (p_r9) else $error("host write not routed"); // see R9

  property p_r10;
    s_q.cfg.expanded_mode_enable |-> pin_oe[p9m_pkg::PIN_RD] &&
      pin_out[p9m_pkg::PIN_RD] == $past(bus_read_strobe);
  endproperty
  a_r10: assert property (p_r10) else $error("read strobe wrong"); // see R10

  property p_r11;
    s_q.cfg.ext_interrupt_zero_enable |->
      ext_interrupt_zero == $past(pin_in[p9m_pkg::PIN_INT_ZRO]);
  endproperty
  a_r11: assert property (p_r11) else $error("irq zero not fed"); // see R11

  property p_r12;
    s_q.cfg.ext_interrupt_one_enable |->
      ext_interrupt_one == $past(pin_in[p9m_pkg::PIN_INT_ONE]) &&
      pin_oe[p9m_pkg::PIN_INT_ONE] == s_q.dir[p9m_pkg::PIN_INT_ONE];
  endproperty
  a_r12: assert property (p_r12) else $error("irq one not fed"); // see R12

  property p_r13;
    s_q.cfg.expanded_mode_enable && !s_q.cfg.bus_width_select |->
      pin_oe[p9m_pkg::PIN_LOW_WR] &&
      pin_out[p9m_pkg::PIN_LOW_WR] == $past(low_write_strobe);
  endproperty
  a_r13: assert property (p_r13) else $error("low write wrong"); // see R13

  property p_r14;
    !s_q.cfg.expanded_mode_enable && s_q.cfg.host_port_enable &&
    s_q.cfg.fast_gate_a20_enable && s_q.cfg.host_select_two_enable |->
      !pin_oe[p9m_pkg::PIN_LOW_WR] &&
      host_select_two == $past(pin_in[p9m_pkg::PIN_LOW_WR]);
  endproperty
  a_r14: assert property (p_r14) else $error("select two wrong"); // see R14

  property p_r15;
    s_q.cfg.ext_interrupt_two_enable && (!s_q.cfg.expanded_mode_enable ||
    s_q.cfg.bus_width_select) |->
      ext_interrupt_two == $past(pin_in[p9m_pkg::PIN_LOW_WR]);
  endproperty
  a_r15: assert property (p_r15) else $error("irq two not fed"); // see R15

  property p_r16;
    s_q.cfg.converter_trigger_select_hi &&
    s_q.cfg.converter_trigger_select_lo |->
      converter_ext_trigger == $past(pin_in[p9m_pkg::PIN_LOW_WR]);
  endproperty
  a_r16: assert property (p_r16) else $error("trigger not fed"); // see R16

  property p_r17;
    wr_done && addr8 == p9m_pkg::OFF_DIR |=> s_q.dir == $past(pwdata[7:0]);
  endproperty
  a_r17: assert property (p_r17) else $error("dir write lost"); // see R17

  // direction is write-only, so its read must come back empty
  property p_r17_rd;
    setup && addr8 == p9m_pkg::OFF_DIR |=> prdata == 32'h0000_0000;
  endproperty
  a_r17_rd: assert property (p_r17_rd) else $error("dir not zero"); // see R17

  property p_r18;
    wr_done && addr8 == p9m_pkg::OFF_DATA && s_q.dir[p9m_pkg::PIN_INT_ZRO]
    |=> pin_oe[p9m_pkg::PIN_INT_ZRO] &&
        pin_out[p9m_pkg::PIN_INT_ZRO] == $past(pwdata[p9m_pkg::PIN_INT_ZRO]);
  endproperty
  a_r18: assert property (p_r18) else $error("latch not on pin"); // see R18

endmodule

// [p9m_pkg.sv]
package p9m_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] OFF_DATA  = 8'h00;
  localparam logic [7:0] OFF_DIR   = 8'h04;
  localparam logic [7:0] OFF_CFG   = 8'h08;
  localparam logic [7:0] OFF_DRIVE = 8'h0C;

  // pin positions inside the port
  localparam int unsigned PIN_LOW_WR  = 0;
  localparam int unsigned PIN_INT_ONE = 1;
  localparam int unsigned PIN_INT_ZRO = 2;
  localparam int unsigned PIN_RD      = 3;
  localparam int unsigned PIN_HI_WR   = 4;
  localparam int unsigned PIN_ADDR_ST = 5;
  localparam int unsigned PIN_CLK     = 6;
  localparam int unsigned PIN_SDA     = 7;

  // reset values and the read-only latch bit
  localparam logic [7:0] DIR_RST_SINGLE = 8'h00;
  localparam logic [7:0] DIR_RST_MODE1  = 8'h40;
  localparam logic [7:0] LATCH_RST      = 8'h00;
  localparam logic [7:0] RO_MASK        = 8'h40;

  // mode and enable bits gathered from the surrounding units
  typedef struct packed {
    logic expanded_mode_enable;
    logic wait_mode_select_hi;
    logic i2c_unit_enable;
    logic subclock_input_enable;
    logic io_space_strobe_enable;
    logic host_port_enable;
    logic ext_interrupt_two_enable;
    logic ext_interrupt_one_enable;
    logic ext_interrupt_zero_enable;
    logic bus_width_select;
    logic host_select_two_enable;
    logic fast_gate_a20_enable;
    logic converter_trigger_select_hi;
    logic converter_trigger_select_lo;
  } p9m_cfg_t;

  localparam int unsigned CFG_W   = $bits(p9m_cfg_t);
  localparam p9m_cfg_t    CFG_RST = p9m_cfg_t'(14'h0000);

  // levels handed from the pins to other on-chip units
  typedef struct packed {
    logic wait_input;
    logic i2c_data_line_zero;
    logic subclock_input;
    logic host_select_one;
    logic host_write_strobe;
    logic host_read_strobe;
    logic ext_interrupt_zero;
    logic ext_interrupt_one;
    logic ext_interrupt_two;
    logic converter_ext_trigger;
    logic host_select_two;
  } p9m_feed_t;

  // unused feeds sit high, the inactive level of these strobes
  localparam p9m_feed_t FEED_IDLE = p9m_feed_t'(11'h7FF);

  // signals from other on-chip units that may drive the pins
  typedef struct packed {
    logic address_strobe;
    logic io_space_strobe;
    logic high_write_strobe;
    logic bus_read_strobe;
    logic low_write_strobe;
    logic sysclk_out;
    logic i2c_drive_low;
  } p9m_src_t;

endpackage

// [p9m_mux_if.sv]
interface p9m_mux_if;
  logic [7:0]         latch;
  logic [7:0]         dir;
  p9m_pkg::p9m_cfg_t  cfg;
  logic [7:0]         pin_in;
  p9m_pkg::p9m_src_t  src;
  logic [7:0]         pin_out;
  logic [7:0]         pin_oe;
  p9m_pkg::p9m_feed_t feed;

  modport ctrl (output latch, dir, cfg, pin_in, src,
                input  pin_out, pin_oe, feed);
  modport mux  (input  latch, dir, cfg, pin_in, src,
                output pin_out, pin_oe, feed);
endinterface

// [p9m_pin_mux.sv]
module p9m_pin_mux (
  p9m_mux_if.mux m
);

  // per-pin function selection; purely combinational
  always_comb begin
    m.pin_out = m.latch;
    m.pin_oe  = m.dir;
    m.feed    = p9m_pkg::FEED_IDLE;
    // pin 7: wait input, i2c data or general i/o
    if (m.cfg.expanded_mode_enable && m.cfg.wait_mode_select_hi) begin // see R4
      m.pin_oe[p9m_pkg::PIN_SDA]  = 1'b0;
      m.pin_out[p9m_pkg::PIN_SDA] = 1'b0;
      m.feed.wait_input = m.pin_in[p9m_pkg::PIN_SDA];
    end else if (m.cfg.i2c_unit_enable) begin // see R4 see R5
      // open drain: enable only while pulling low
      m.pin_out[p9m_pkg::PIN_SDA] = 1'b0;
      m.pin_oe[p9m_pkg::PIN_SDA]  = m.src.i2c_drive_low;
      m.feed.i2c_data_line_zero   = m.pin_in[p9m_pkg::PIN_SDA];
    end
    // pin 6: clock out when driven, else subclock or input
    if (m.dir[p9m_pkg::PIN_CLK]) begin // see R6
      m.pin_out[p9m_pkg::PIN_CLK] = m.src.sysclk_out;
    end else if (m.cfg.subclock_input_enable) begin // see R6
      m.feed.subclock_input = m.pin_in[p9m_pkg::PIN_CLK];
    end
    // pins 5..3: bus strobes out, or host strobes in
    if (m.cfg.expanded_mode_enable) begin // see R8 see R9 see R10
      m.pin_oe[p9m_pkg::PIN_ADDR_ST]  = 1'b1;
      m.pin_out[p9m_pkg::PIN_ADDR_ST] = m.cfg.io_space_strobe_enable ?
          m.src.io_space_strobe : m.src.address_strobe;
      m.pin_oe[p9m_pkg::PIN_HI_WR]    = 1'b1;
      m.pin_out[p9m_pkg::PIN_HI_WR]   = m.src.high_write_strobe;
      m.pin_oe[p9m_pkg::PIN_RD]       = 1'b1;
      m.pin_out[p9m_pkg::PIN_RD]      = m.src.bus_read_strobe;
    end else if (m.cfg.host_port_enable) begin // see R8 see R9 see R10
      m.pin_oe[p9m_pkg::PIN_ADDR_ST] = 1'b0;
      m.pin_oe[p9m_pkg::PIN_HI_WR]   = 1'b0;
      m.pin_oe[p9m_pkg::PIN_RD]      = 1'b0;
      m.feed.host_select_one   = m.pin_in[p9m_pkg::PIN_ADDR_ST];
      m.feed.host_write_strobe = m.pin_in[p9m_pkg::PIN_HI_WR];
      m.feed.host_read_strobe  = m.pin_in[p9m_pkg::PIN_RD];
    end
    // pins 2 and 1 stay general i/o, level also reaches interrupts
    if (m.cfg.ext_interrupt_zero_enable) begin // see R11
      m.feed.ext_interrupt_zero = m.pin_in[p9m_pkg::PIN_INT_ZRO];
    end
    if (m.cfg.ext_interrupt_one_enable) begin // see R12
      m.feed.ext_interrupt_one = m.pin_in[p9m_pkg::PIN_INT_ONE];
    end
    // pin 0: low write strobe, host select two, or general i/o
    if (m.cfg.expanded_mode_enable && !m.cfg.bus_width_select) begin // see R13
      m.pin_oe[p9m_pkg::PIN_LOW_WR]  = 1'b1;
      m.pin_out[p9m_pkg::PIN_LOW_WR] = m.src.low_write_strobe;
    end else if (!m.cfg.expanded_mode_enable && m.cfg.host_port_enable &&
                 m.cfg.fast_gate_a20_enable &&
                 m.cfg.host_select_two_enable) begin // see R14
      m.pin_oe[p9m_pkg::PIN_LOW_WR] = 1'b0;
      m.feed.host_select_two = m.pin_in[p9m_pkg::PIN_LOW_WR];
    end
    if (m.cfg.ext_interrupt_two_enable && (!m.cfg.expanded_mode_enable ||
        m.cfg.bus_width_select)) begin // see R15
      m.feed.ext_interrupt_two = m.pin_in[p9m_pkg::PIN_LOW_WR];
    end
    if (m.cfg.converter_trigger_select_hi &&
        m.cfg.converter_trigger_select_lo) begin // see R16
      m.feed.converter_ext_trigger = m.pin_in[p9m_pkg::PIN_LOW_WR];
    end
  end

endmodule

// [p9m_board.sv]
module p9m_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // device drive wins; a released pin takes ext_val where ext_en is set, else the board pull-up level,
  // which also covers the open-drain data line on pin 7
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (pin_oe[b]) begin
        pin_in[b] = pin_out[b];
      end else if (ext_en[b]) begin
        pin_in[b] = ext_val[b];
      end else begin
        pin_in[b] = 1'b1;
      end
    end
  end
endmodule

// [p9m_port9_tb.sv]
module p9m_port9_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic               mode_one = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [7:0]         pin_in;
  logic [7:0]         pin_out;
  logic [7:0]         pin_oe;
  logic [7:0]         ext_val = 8'h00;
  logic [7:0]         ext_en = 8'hFF;
  p9m_pkg::p9m_src_t  src = 7'h02;
  p9m_pkg::p9m_feed_t feed_v;
  p9m_pkg::p9m_feed_t e;
  int                 bad_count = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  logic [31:0]        rd;
  logic               er;
  logic [7:0]         strb;

  // strobe pins 5..3 and 0: enables then drive values
  assign strb = {pin_oe[5:3], pin_oe[0], pin_out[5:3], pin_out[0]};

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  p9m_port9 p9m_port9_i (
    .clk_sys               (clk_sys),
    .nrst                  (nrst),
    .mode_one              (mode_one),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .pin_in                (pin_in),
    .pin_out               (pin_out),
    .pin_oe                (pin_oe),
    .address_strobe        (src.address_strobe),
    .io_space_strobe       (src.io_space_strobe),
    .high_write_strobe     (src.high_write_strobe),
    .bus_read_strobe       (src.bus_read_strobe),
    .low_write_strobe      (src.low_write_strobe),
    .sysclk_out            (src.sysclk_out),
    .i2c_drive_low         (src.i2c_drive_low),
    .wait_input            (feed_v.wait_input),
    .i2c_data_line_zero    (feed_v.i2c_data_line_zero),
    .subclock_input        (feed_v.subclock_input),
    .host_select_one       (feed_v.host_select_one),
    .host_write_strobe     (feed_v.host_write_strobe),
    .host_read_strobe      (feed_v.host_read_strobe),
    .ext_interrupt_zero    (feed_v.ext_interrupt_zero),
    .ext_interrupt_one     (feed_v.ext_interrupt_one),
    .ext_interrupt_two     (feed_v.ext_interrupt_two),
    .converter_ext_trigger (feed_v.converter_ext_trigger),
    .host_select_two       (feed_v.host_select_two)
  );

  p9m_board p9m_board_i (
    .pin_out (pin_out),
    .pin_oe  (pin_oe),
    .ext_val (ext_val),
    .ext_en  (ext_en),
    .pin_in  (pin_in)
  );

  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang anywhere ends the run as a failure
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // pins change at the write's own edge; feeds from driven pins follow one edge later
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic rst(input logic m);
    @(posedge clk_sys);
    nrst <= 1'b0;
    mode_one <= m;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic t_reset();
    rst(1'b1);
    settle();
    chk(32'(pin_oe), 32'h79);
    chk(32'(pin_out[6]), 32'h1);
    rdc(p9m_pkg::OFF_DIR, 32'h0);
    rdc(p9m_pkg::OFF_CFG, 32'h2000);
    ext_val <= 8'h5A;
    rst(1'b0);
    settle();
    chk(32'(pin_oe), 32'h0);
    rdc(p9m_pkg::OFF_DATA, 32'h5A);
  endtask

  task automatic t_gpio();
    ext_val <= 8'h3C;
    wr(p9m_pkg::OFF_DATA, 32'hA5);
    wr(p9m_pkg::OFF_DIR, 32'h0F);
    settle();
    chk(32'(pin_oe), 32'h0F);
    chk(32'(pin_out[3:0]), 32'h5);
    rdc(p9m_pkg::OFF_DATA, 32'h35);
    wr(p9m_pkg::OFF_DIR, 32'h4F);
    settle();
    rdc(p9m_pkg::OFF_DATA, 32'h75);
    rdc(p9m_pkg::OFF_DRIVE, 32'h4F);
  endtask

  task automatic t_pin7();
    ext_val <= 8'h00;
    wr(p9m_pkg::OFF_DIR, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(p9m_pkg::OFF_CFG, 32'(i) << 11);
      settle();
      e = p9m_pkg::FEED_IDLE;
      e.wait_input = ~(i[2] & i[1]);
      e.i2c_data_line_zero = ~(~(i[2] & i[1]) & i[0]);
      chk(32'(feed_v), 32'(e));
    end
    // i2c unit pulling the open-drain line low
    src <= 7'h03;
    wr(p9m_pkg::OFF_CFG, 32'h0800);
    settle();
    chk(32'({pin_oe[7], pin_out[7]}), 32'h2);
  endtask

  task automatic t_strobe();
    src <= 7'h5A;
    wr(p9m_pkg::OFF_CFG, 32'h2000);
    settle();
    chk(32'(strb), 32'hFE);
    wr(p9m_pkg::OFF_CFG, 32'h2200);
    settle();
    chk(32'(strb), 32'hF6);
    wr(p9m_pkg::OFF_CFG, 32'h2210);
    settle();
    chk(32'(pin_oe & 8'h39), 32'h38);
  endtask

  task automatic t_host();
    wr(p9m_pkg::OFF_CFG, 32'h010C);
    settle();
    e = p9m_pkg::FEED_IDLE;
    e.host_select_one = 1'b0;
    e.host_write_strobe = 1'b0;
    e.host_read_strobe = 1'b0;
    e.host_select_two = 1'b0;
    chk(32'(feed_v), 32'(e));
    chk(32'(pin_oe), 32'h0);
    wr(p9m_pkg::OFF_CFG, 32'h0108);
    settle();
    e.host_select_two = 1'b1;
    chk(32'(feed_v), 32'(e));
  endtask

  task automatic t_irq();
    wr(p9m_pkg::OFF_CFG, 32'h00E3);
    settle();
    e = p9m_pkg::FEED_IDLE;
    e.ext_interrupt_zero = 1'b0;
    e.ext_interrupt_one = 1'b0;
    e.ext_interrupt_two = 1'b0;
    e.converter_ext_trigger = 1'b0;
    chk(32'(feed_v), 32'(e));
    // narrow expanded bus: pin 0 carries the low write strobe, driven low,
    // so the trigger still sees it while interrupt two stays idle
    wr(p9m_pkg::OFF_CFG, 32'h20E3);
    settle();
    e.ext_interrupt_two = 1'b1;
    chk(32'(feed_v), 32'(e));
    wr(p9m_pkg::OFF_CFG, 32'h0002);
    settle();
    chk(32'(feed_v), 32'(p9m_pkg::FEED_IDLE));
  endtask

  task automatic t_sub();
    wr(p9m_pkg::OFF_DIR, 32'h0);
    wr(p9m_pkg::OFF_CFG, 32'h0400);
    settle();
    e = p9m_pkg::FEED_IDLE;
    e.subclock_input = 1'b0;
    chk(32'(feed_v), 32'(e));
    chk(32'(pin_oe), 32'h0);
  endtask

  task automatic t_unmap();
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h14, 32'h3FFF);
    chk(32'(er), 32'h1);
    rdc(p9m_pkg::OFF_CFG, 32'h0400);
  endtask

  initial begin
    t_reset();
    t_gpio();
    t_pin7();
    t_strobe();
    t_host();
    t_irq();
    t_sub();
    t_unmap();
    give_verdict();
  end
endmodule
